// file: verif/interrupt_entry_exit_sequencer_test.sv
// self-checking bench for the interrupt sequencer pair
`timescale 1ns/100ps
module interrupt_entry_exit_sequencer_test;
	import irq_seq_pkg::*;
	logic mclk = 0, rst = 1, instr_done = 0, trap_fetched = 0, return_exec = 0;
	logic wait_exec = 0, stop_exec = 0, mask_wr = 0, mask_wr_val = 0, took = 0;
	logic [15:0] pc_cur = 16'h1234, sp_cur = 16'h00f0, rd_a = 16'h0;
	logic [7:0] acc_cur = 8'h88, x_cur = 8'h77, ccr_cur = 8'h00;
	logic [125:0] req = '0, len = '1, svc, svc_got = '0;
	logic [7:0] mem [0:65535];
	wire [7:0] mem_rdata = mem[rd_a];
	logic [15:0] mem_addr, pc_new, sp_new;
	logic [7:0] mem_wdata, acc_new, x_new, ccr_new;
	logic mem_we, mem_re, pc_load, regs_load, mask, core_hold, core_clk_run, sys_clk_run;
	logic [6:0] tcode;
	int failures = 0, check_count = 0, cyc = 0;
	irq_link_if link();
	irq_core_seq u_irq_core_seq (.mclk(mclk), .rst(rst), .link(link), .instr_done(instr_done),
		.trap_fetched(trap_fetched), .return_exec(return_exec), .wait_exec(wait_exec),
		.stop_exec(stop_exec), .mask_wr(mask_wr), .mask_wr_val(mask_wr_val), .pc_cur(pc_cur),
		.acc_cur(acc_cur), .x_cur(x_cur), .ccr_cur(ccr_cur), .sp_cur(sp_cur),
		.mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
		.mem_re(mem_re), .pc_new(pc_new), .pc_load(pc_load), .sp_new(sp_new),
		.acc_new(acc_new), .x_new(x_new), .ccr_new(ccr_new), .regs_load(regs_load),
		.mask(mask), .core_hold(core_hold), .core_clk_run(core_clk_run),
		.sys_clk_run(sys_clk_run));
	// one stop-capable source so the stop wake path is reached
	irq_sim_arb #(.STOP_WAKE_EN(126'h1 << 20)) u_irq_sim_arb (.mclk(mclk), .rst(rst),
		.link(link), .hw_request_line(req), .local_en(len), .serviced(svc));
	irq_seq_chk u_irq_seq_chk (.mclk(mclk), .rst(rst), .req_valid(link.req_valid),
		.req_code(link.req_code), .stop_wake(link.stop_wake), .take(link.take),
		.take_code(link.take_code), .in_wait(link.in_wait), .in_stop(link.in_stop));
	always #2.5 mclk = ~mclk;
	// memory model and take monitor; read data lags the strobe by one cycle
	always @(posedge mclk)
	begin
		if (mem_we) mem[mem_addr] <= mem_wdata;
		if (mem_re) rd_a <= mem_addr;
		if (link.take) took <= 1'b1;
		if (link.take) tcode <= link.take_code;
		if (|svc) svc_got <= svc;
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			failures++;
			close_out;
		end
	end
	task chk_w(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_b(input logic g, input logic e);
		chk_w({15'h0, g}, {15'h0, e});
	endtask
	task automatic pls(ref logic s);
		s = 1'b1;
		@(negedge mclk);
		s = 1'b0;
	endtask
	// handler address held in the vector pair of slot idx
	function automatic logic [15:0] hv(input int idx);
		logic [15:0] a;
		a = 16'hfffe - 16'(2 * idx);
		hv = {mem[a], mem[a + 16'h1]};
	endfunction
	task wait_load;
		int n;
		n = 0;
		while (pc_load !== 1'b1 && n < 40)
		begin
			@(negedge mclk);
			n++;
		end
		chk_b(pc_load, 1'b1);
	endtask
	task entry(input int idx, input logic tk, input logic [6:0] code);
		wait_load;
		chk_w(pc_new, hv(idx));
		chk_w(sp_new, sp_cur - 16'h5);
		chk_b(mask, 1'b1);
		chk_b(took, tk);
		if (tk) chk_w({9'h0, tcode}, {9'h0, code});
		chk_w({mem[sp_cur], mem[sp_cur - 1]}, {pc_cur[7:0], pc_cur[15:8]});
		chk_w({mem[sp_cur - 2], mem[sp_cur - 3]}, {x_cur, acc_cur});
		chk_w({8'h0, mem[sp_cur - 4]}, 16'h0);
		chk_b(svc_got == (tk ? 126'h1 << code : 126'h0), 1'b1);
		took = 0;
		svc_got = '0;
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		for (int i = 16'hff00; i < 65536; i++) mem[i] = i[7:0] ^ 8'h3c;
		repeat (6) @(negedge mclk);
		rst = 0;
		wait_load;
		chk_w(pc_new, hv(0));
		chk_w(sp_new, 16'h00ff);
		chk_b(mask, 1'b1);
		$display("reset test done");
		// masked requests stay pending
		req[5] = 1'b1;
		req[9] = 1'b1;
		repeat (2) @(negedge mclk);
		pls(instr_done);
		repeat (4) @(negedge mclk);
		chk_b(took, 1'b0);
		chk_b(core_hold, 1'b0);
		$display("masked test done");
		pls(mask_wr);
		pls(instr_done);
		entry(7, 1'b1, 7'd5);
		req[5] = 1'b0;
		repeat (3) @(negedge mclk);
		chk_w({9'h0, link.req_code}, 16'h0009);
		// a locally disabled source never reaches the core
		len[9] = 1'b0;
		repeat (2) @(negedge mclk);
		chk_b(link.req_valid, 1'b0);
		len[9] = 1'b1;
		$display("entry test done");
		sp_cur = 16'h00eb;
		pls(return_exec);
		chk_b(core_hold, 1'b1);
		repeat (2) @(negedge mclk);
		chk_b(mask, 1'b0);
		wait_load;
		chk_b(regs_load, 1'b1);
		chk_w({8'h0, ccr_new}, 16'h0000);
		chk_w(pc_new, 16'h1234);
		chk_w({acc_new, x_new}, 16'h8877);
		chk_w(sp_new, 16'h00f0);
		sp_cur = 16'h00f0;
		@(negedge mclk);
		chk_b(mask, 1'b0);
		$display("return test done");
		pls(trap_fetched);
		pls(instr_done);
		entry(1, 1'b0, 7'd0);
		$display("trap test done");
		pls(wait_exec);
		chk_b(core_clk_run, 1'b0);
		entry(11, 1'b1, 7'd9);
		$display("wait test done");
		pls(stop_exec);
		repeat (6) @(negedge mclk);
		chk_b(took, 1'b0);
		chk_b(sys_clk_run, 1'b0);
		// a stop-capable source wakes the part; the winner is still served
		req[20] = 1'b1;
		entry(11, 1'b1, 7'd9);
		$display("stop test done");
		close_out;
	end
endmodule

// file: verif/irq_seq_chk.sv
// link protocol checker for the sequencer pair
`timescale 1ns/100ps
module irq_seq_chk (
	input wire logic mclk, // clock
	input wire logic rst, // reset
	input wire logic req_valid, // winner valid
	input wire logic [6:0] req_code, // winner code
	input wire logic stop_wake, // stop wake
	input wire logic take, // entry taken
	input wire logic [6:0] take_code, // taken code
	input wire logic in_wait, // wait mode
	input wire logic in_stop // stop mode
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_rst_idle; $fell(rst) |-> !req_valid && !take; endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("link busy after reset");
	property p_one_entry; take |=> !take [*8]; endproperty
	a_one_entry: assert property (p_one_entry) else $error("entries overlap");
	property p_take_cause; take |-> $past(req_valid); endproperty
	a_take_cause: assert property (p_take_cause) else $error("take without request");
	property p_take_code; take |-> take_code == $past(req_code); endproperty
	a_take_code: assert property (p_take_code) else $error("wrong code taken");
	property p_code_range; req_valid |-> req_code < 7'd126; endproperty
	a_code_range: assert property (p_code_range) else $error("code out of range");
	property p_wait_wake; in_wait && req_valid |=> take; endproperty
	a_wait_wake: assert property (p_wait_wake) else $error("wait not woken");
	property p_stop_hold; in_stop && !(stop_wake && req_valid) |=> !take; endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop woken");
	property p_wake_exit; take |=> !in_wait && !in_stop; endproperty
	a_wake_exit: assert property (p_wake_exit) else $error("still asleep");
	c_take: cover property (take);
	c_wait_take: cover property (in_wait ##1 take);
	c_stop: cover property (in_stop && req_valid);
endmodule

// file: verilog/irq_core_seq.sv
// core-side interrupt entry, vector fetch, return and low-power sequencer
`timescale 1ns/100ps
module irq_core_seq
	import irq_seq_pkg::*;
(
	input wire logic mclk, // core clock
	input wire logic rst, // synchronous reset, high
	irq_link_if.core_end link, // arbiter link
	input wire logic instr_done, // current instruction completes
	input wire logic trap_fetched, // software trap opcode fetched
	input wire logic return_exec, // return from handler decoded
	input wire logic wait_exec, // wait instruction executed
	input wire logic stop_exec, // stop instruction executed
	input wire logic mask_wr, // clear/set mask or flags transfer
	input wire logic mask_wr_val, // new mask value
	input wire logic [15:0] pc_cur, // return address to stack
	input wire logic [7:0] acc_cur, // accumulator
	input wire logic [7:0] x_cur, // index low byte
	input wire logic [7:0] ccr_cur, // condition flags
	input wire logic [15:0] sp_cur, // stack pointer
	input wire logic [7:0] mem_rdata, // read data, one cycle after read
	output logic [15:0] mem_addr, // memory address
	output logic [7:0] mem_wdata, // memory write data
	output logic mem_we, // write strobe
	output logic mem_re, // read strobe
	output logic [15:0] pc_new, // new program counter
	output logic pc_load, // load pc_new and sp_new
	output logic [15:0] sp_new, // new stack pointer
	output logic [7:0] acc_new, // restored accumulator
	output logic [7:0] x_new, // restored index low
	output logic [7:0] ccr_new, // restored flags
	output logic regs_load, // load restored registers
	output logic mask, // global interrupt mask
	output logic core_hold, // stall instruction flow
	output logic core_clk_run, // core clock enable
	output logic sys_clk_run // system clock enable
);
	typedef struct packed {
		seq_state_t st;
		logic [2:0] step;
		logic [6:0] idx;
		logic mask;
		logic lock;
		logic [15:0] sp;
		logic [15:0] pc;
		logic [7:0] acc;
		logic [7:0] x;
		logic [7:0] condition_flags_reg;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
		logic take;
		logic pc_load;
		logic regs_load;
	} core_st_t;

	// reset enters the vector fetch of slot zero with the mask set
	localparam core_st_t RESET_ST = '{st: ST_VEC_HI, step: 3'h0, idx: IDX_RESET,
		mask: 1'b1, lock: 1'b0, sp: SP_RESET, pc: 16'h0000, acc: 8'h00, x: 8'h00,
		condition_flags_reg: 8'h00, addr: 16'h0000, wdata: 8'h00, we: 1'b0, re: 1'b0, take: 1'b0,
		pc_load: 1'b0, regs_load: 1'b0};

	core_st_t s_q;
	core_st_t s_d;
	logic start;
	logic [6:0] start_idx;
	logic hw_ok;

	// request admission and entry start
	always_comb
	begin
		hw_ok = link.req_valid && !s_q.mask;
		start = 1'b0;
		start_idx = IDX_TRAP;
		unique case (s_q.st)
			ST_IDLE:
				if (instr_done && !return_exec)
				begin
					if (s_q.lock)
						start = 1'b1;
					else if (hw_ok)
					begin
						start = 1'b1;
						start_idx = IDX_HW_BASE + link.req_code;
					end
				end
			ST_WAIT:
				if (hw_ok)
				begin
					start = 1'b1;
					start_idx = IDX_HW_BASE + link.req_code;
				end
			ST_STOP:
				if (link.stop_wake && hw_ok)
				begin
					start = 1'b1;
					start_idx = IDX_HW_BASE + link.req_code;
				end
			ST_PUSH, ST_VEC_HI, ST_VEC_LO, ST_VEC_END, ST_PULL:
				start = 1'b0;
		endcase
	end

	// sequencer next state
	always_comb
	begin
		s_d = s_q;
		s_d.we = 1'b0;
		s_d.re = 1'b0;
		s_d.take = 1'b0;
		s_d.pc_load = 1'b0;
		s_d.regs_load = 1'b0;
		if (trap_fetched)
			s_d.lock = 1'b1;
		unique case (s_q.st)
			ST_IDLE:
			begin
				// software mask writes land at once
				if (mask_wr)
					s_d.mask = mask_wr_val;
				if (return_exec)
				begin
					s_d.st = ST_PULL;
					s_d.step = 3'h0;
					s_d.sp = sp_cur + 16'h0001;
					s_d.addr = sp_cur + 16'h0001;
					s_d.re = 1'b1;
				end
				else if (wait_exec)
				begin
					s_d.st = ST_WAIT;
					s_d.mask = 1'b0;
				end
				else if (stop_exec)
				begin
					s_d.st = ST_STOP;
					s_d.mask = 1'b0;
				end
			end
			// stack pc low, pc high, x, acc, flags
			ST_PUSH:
			begin
				s_d.addr = s_q.sp;
				s_d.we = 1'b1;
				unique case (s_q.step)
					3'h0: s_d.wdata = s_q.pc[7:0];
					3'h1: s_d.wdata = s_q.pc[15:8];
					3'h2: s_d.wdata = s_q.x;
					3'h3: s_d.wdata = s_q.acc;
					default: s_d.wdata = s_q.condition_flags_reg;
				endcase
				s_d.sp = s_q.sp - 16'h0001;
				s_d.step = s_q.step + 3'h1;
				if (s_q.step == STACK_BYTES - 3'h1)
					s_d.st = ST_VEC_HI;
			end
			ST_VEC_HI:
			begin
				s_d.addr = vec_addr(s_q.idx);
				s_d.re = 1'b1;
				s_d.st = ST_VEC_LO;
			end
			ST_VEC_LO:
			begin
				s_d.addr = s_q.addr + 16'h0001;
				s_d.re = 1'b1;
				s_d.step = 3'h0;
				s_d.st = ST_VEC_END;
			end
			// load handler address; data trails its strobe by a cycle
			ST_VEC_END:
			begin
				s_d.step = 3'h1;
				if (s_q.step == 3'h0)
					s_d.pc[15:8] = mem_rdata;
				else
				begin
					s_d.pc[7:0] = mem_rdata;
					s_d.pc_load = 1'b1;
					s_d.st = ST_IDLE;
					// trap lock ends with its vector
					if (s_q.idx == IDX_TRAP)
						s_d.lock = trap_fetched;
				end
			end
			// pull flags, acc, x, pc high, pc low
			ST_PULL:
			begin
				s_d.step = s_q.step + 3'h1;
				if (s_q.step < STACK_BYTES - 3'h1)
				begin
					s_d.addr = s_q.addr + 16'h0001;
					s_d.re = 1'b1;
				end
				unique case (s_q.step)
					3'h0: s_d.condition_flags_reg = s_q.condition_flags_reg;
					3'h1:
					begin
						s_d.condition_flags_reg = mem_rdata;
						s_d.mask = mem_rdata[MASK_BIT];
					end
					3'h2: s_d.acc = mem_rdata;
					3'h3: s_d.x = mem_rdata;
					3'h4: s_d.pc[15:8] = mem_rdata;
					default:
					begin
						s_d.pc[7:0] = mem_rdata;
						s_d.sp = s_q.addr;
						s_d.pc_load = 1'b1;
						s_d.regs_load = 1'b1;
						s_d.st = ST_IDLE;
					end
				endcase
			end
			ST_WAIT, ST_STOP:
				s_d.st = s_q.st;
		endcase
		// snapshot registers and raise mask on entry
		if (start)
		begin
			s_d.st = ST_PUSH;
			s_d.step = 3'h0;
			s_d.idx = start_idx;
			s_d.sp = sp_cur;
			s_d.pc = pc_cur;
			s_d.acc = acc_cur;
			s_d.x = x_cur;
			// flags stacked with the mask as it stood before entry
			s_d.condition_flags_reg = ccr_cur;
			s_d.condition_flags_reg[MASK_BIT] = s_q.mask;
			s_d.mask = 1'b1;
			s_d.take = (start_idx != IDX_TRAP);
		end
	end

	// state register; reset forces mask set
	always_ff @(posedge mclk)
	begin
		if (rst)
			s_q <= RESET_ST;
		else
			s_q <= s_d;
	end

	// outputs
	assign mem_addr = s_q.addr;
	assign mem_wdata = s_q.wdata;
	assign mem_we = s_q.we;
	assign mem_re = s_q.re;
	assign pc_new = s_q.pc;
	assign pc_load = s_q.pc_load;
	assign sp_new = s_q.sp;
	assign acc_new = s_q.acc;
	assign x_new = s_q.x;
	assign ccr_new = s_q.condition_flags_reg;
	assign regs_load = s_q.regs_load;
	assign mask = s_q.mask;
	// core stalls whenever the sequencer owns the bus or sleeps
	assign core_hold = (s_q.st != ST_IDLE);
	assign core_clk_run = (s_q.st != ST_WAIT) && (s_q.st != ST_STOP);
	assign sys_clk_run = (s_q.st != ST_STOP);
	assign link.take = s_q.take;
	assign link.take_code = s_q.idx - IDX_HW_BASE;
	assign link.in_wait = (s_q.st == ST_WAIT);
	assign link.in_stop = (s_q.st == ST_STOP);
endmodule

// file: verilog/irq_link_if.sv
// link between core interrupt sequencer and system integration arbiter
`timescale 1ns/100ps
interface irq_link_if;
	logic req_valid;
	logic [irq_seq_pkg::CODE_W-1:0] req_code;
	logic stop_wake;
	logic take;
	logic [irq_seq_pkg::CODE_W-1:0] take_code;
	logic in_wait;
	logic in_stop;

	modport core_end (
		input req_valid, req_code, stop_wake,
		output take, take_code, in_wait, in_stop
	);
	modport sim_end (
		output req_valid, req_code, stop_wake,
		input take, take_code, in_wait, in_stop
	);
endinterface

// file: verilog/irq_seq_pkg.sv
// constants and types shared by the interrupt sequencer and the request arbiter
// Functional notes
// - take request only at instruction boundary
// - stack all registers except index high
// - load winner vector, resume at handler
// - return pulls flags, registers, return address
// - global mask clear and local enable
// - entry sets global mask bit
// - return restores stacked mask bit state
// - reset sets mask until software clears
// - 128 vectors: reset, trap, 126 requests
// - vectors descend by two from top
// - arbiter request served at next boundary
// - arbiter encodes highest priority winner
// - fetched trap blocks others until vectored
// - wait mode wakes on enabled request
// - stop wake only from capable sources
// - serve winner only, others stay pending
// - mask change effective before final cycle
// - mask restored in return's second cycle
package irq_seq_pkg;
	localparam int NUM_VEC = 128;
	localparam int NUM_REQ = 126;
	localparam int CODE_W = 7;
	localparam logic [15:0] VEC_TOP = 16'hfffe;
	localparam logic [15:0] VEC_STEP = 16'h0002;
	localparam logic [6:0] IDX_RESET = 7'h00;
	localparam logic [6:0] IDX_TRAP = 7'h01;
	localparam logic [6:0] IDX_HW_BASE = 7'h02;
	localparam int MASK_BIT = 3;
	localparam logic [15:0] SP_RESET = 16'h00ff;
	localparam logic [2:0] STACK_BYTES = 3'h5;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PUSH = 3'b001,
		ST_VEC_HI = 3'b010,
		ST_VEC_LO = 3'b011,
		ST_VEC_END = 3'b100,
		ST_PULL = 3'b101,
		ST_WAIT = 3'b110,
		ST_STOP = 3'b111
	} seq_state_t;

	function automatic logic [15:0] vec_addr(input logic [6:0] idx);
		vec_addr = VEC_TOP - VEC_STEP * {9'h000, idx};
	endfunction
endpackage

// file: verilog/irq_sim_arb.sv
// system integration side: request gating, priority encode, acknowledge
`timescale 1ns/100ps
module irq_sim_arb
	import irq_seq_pkg::*;
#(
	parameter int NREQ = NUM_REQ,
	parameter logic [NUM_REQ-1:0] STOP_WAKE_EN = '0
)
(
	input wire logic mclk, // core clock
	input wire logic rst, // synchronous reset, high
	irq_link_if.sim_end link, // core link
	input wire logic [NREQ-1:0] hw_request_line, // peripheral request levels
	input wire logic [NREQ-1:0] local_en, // peripheral local enables
	output logic [NREQ-1:0] serviced // one-cycle acknowledge per source
);
	typedef struct packed {
		logic valid;
		logic [CODE_W-1:0] code;
		logic wake;
		logic [NREQ-1:0] ack;
	} sim_st_t;

	sim_st_t s_q;
	sim_st_t s_d;
	logic [NREQ-1:0] live;

	// lowest index wins
	function automatic logic [CODE_W-1:0] first_set(input logic [NREQ-1:0] v);
		first_set = '0;
		for (int i = NREQ - 1; i >= 0; i--)
			if (v[i])
				first_set = CODE_W'(i);
	endfunction

	always_comb
	begin
		live = hw_request_line & local_en;
		s_d.valid = |live;
		s_d.code = first_set(live);
		s_d.wake = |(live & STOP_WAKE_EN[NREQ-1:0]);
		s_d.ack = '0;
		// core takes it at the next boundary
		if (link.take)
			s_d.ack[link.take_code] = 1'b1;
	end

	// registered encoder outputs
	always_ff @(posedge mclk)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign link.req_valid = s_q.valid;
	assign link.req_code = s_q.code;
	assign link.stop_wake = s_q.wake;
	assign serviced = s_q.ack;
endmodule
